/* File: clkgen_pkg.sv */
/*
  Constants for the system clock divider control block: register offsets,
  field positions, reset values and timing counts.
  Assumes a single 25 MHz clock standing in for the oscillator clock.
*/
package clkgen_pkg;
   localparam logic [7:0] ADDR_STANDBY = 8'h00;
   localparam logic [7:0] ADDR_STAB_SEL = 8'h04;
   localparam logic [7:0] ADDR_WAKE_CFG = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam int STBY_HALT_BIT = 0;
   localparam int STBY_STOP_BIT = 1;
   localparam int STBY_DIV_LO_BIT = 4;
   localparam int STBY_DIV_HI_BIT = 5;
   localparam int STBY_SELOSC_BIT = 7;
   localparam logic [7:0] STANDBY_RESET = 8'h30;
   localparam logic [7:0] STANDBY_MASK = 8'hb3;
   localparam logic [2:0] STAB_SEL_RESET = 3'h0;
   localparam logic [3:0] WAKE_CFG_RESET = 4'h0;
   localparam int WAKE_MASK4_BIT = 0;
   localparam int WAKE_MASK5_BIT = 1;
   localparam int WAKE_MS4_BIT = 2;
   localparam int WAKE_MS5_BIT = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int CHG_MAX_DIV1 = 11;
   localparam int CHG_MAX_DIV2 = 12;
   localparam int CHG_MAX_DIV48 = 8;
   localparam int STAB_BASE_SHIFT = 12;
endpackage

/* File: clkgen_ctrl.sv */
/*
  System clock divider control: standby register, stabilization time select,
  wake configuration and status over AXI4-Lite; divider with glitch-free ratio
  switching; oscillator enable and STOP wake-up stabilization timer.
  Assumes the oscillator clock is aclk itself; the divided system clock is
  emitted both as a level and as a one-cycle enable pulse for downstream logic.
*/
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
module clkgen_ctrl
   import clkgen_pkg::*;
#(
   parameter int STAB_SCALE = 1 << STAB_BASE_SHIFT
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address, data and response.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read.
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins.
   input wire logic ext_clock_mode,
   input wire logic osc_input_pin,
   input wire logic nmi_pin,
   input wire logic ext_irq_pin_four,
   input wire logic ext_irq_pin_five,
   input wire logic regulator_disable_pin,
   // Clock and regulator outputs.
   output logic osc_enable,
   output logic ext_clock_fwd,
   output logic sys_clk_level,
   output logic sys_clk_en,
   output logic cpu_clock_gate,
   output logic regulator_on
);

   logic [7:0] standby_control_reg_r;
   logic [2:0] stabilization_time_select_r;
   logic [3:0] wake_cfg_r;
   logic [1:0] div_cur_r;
   logic [1:0] div_req_r;
   logic change_pend_r;
   logic [2:0] phase_r;
   logic [3:0] chg_cnt_r;
   logic [31:0] stab_cnt_r;
   logic stab_busy_r;
   logic stop_r;
   logic [2:0] pin_prev_r;
   logic wake;
   logic [2:0] mask_cur;
   logic [2:0] mask_req;
   logic common_low;
   logic [3:0] chg_limit;
   logic aw_hold_r;
   logic w_hold_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;

   // Divider counter runs free; divide select n (ratio 2 to the n) uses its low n bits.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_r <= 3'h0;
      end else begin
         phase_r <= phase_r + 3'h1;
      end
   end

   function automatic logic [2:0] div_mask(input logic [1:0] sel);
      unique case (sel)
         2'h0: div_mask = 3'h0;
         2'h1: div_mask = 3'h1;
         2'h2: div_mask = 3'h3;
         2'h3: div_mask = 3'h7;
      endcase
   endfunction

   always_comb begin
      mask_cur = div_mask(div_cur_r);
      mask_req = div_mask(div_req_r);
      // Both clocks are at the end of a period when their low bits are all ones.
      common_low = ((phase_r & mask_cur) == mask_cur) && ((phase_r & mask_req) == mask_req);
      unique case (div_cur_r)
         2'h0: chg_limit = 4'(CHG_MAX_DIV1);
         2'h1: chg_limit = 4'(CHG_MAX_DIV2);
         default: chg_limit = 4'(CHG_MAX_DIV48);
      endcase
   end

   // Ratio change: old ratio stays in force until a common boundary.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cur_r <= 2'h3;
         change_pend_r <= 1'b0;
         chg_cnt_r <= 4'h0;
      end else if (change_pend_r) begin
         chg_cnt_r <= chg_cnt_r + 4'h1;
         // Boundary of the longest ratio arrives within 8 cycles, inside every limit.
         if (common_low || chg_cnt_r >= chg_limit - 4'h1) begin
            div_cur_r <= div_req_r;
            change_pend_r <= 1'b0;
         end
      end else if (div_req_r != div_cur_r) begin
         change_pend_r <= 1'b1;
         chg_cnt_r <= 4'h0;
      end
   end

   // Outputs of the divider; during a change the enable stops only for STOP or the stabilization timer.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sys_clk_en <= 1'b0;
         sys_clk_level <= 1'b0;
      end else begin
         sys_clk_en <= ((phase_r & mask_cur) == mask_cur) && !stop_r && !stab_busy_r;
         sys_clk_level <= (mask_cur == 3'h0) ? 1'b1 : (phase_r & mask_cur) <= (mask_cur >> 1);
      end
   end

   // Wake edges; external pins gated by mask and macro service.
   always_comb begin
      wake = (nmi_pin && !pin_prev_r[0])
         || (ext_irq_pin_four && !pin_prev_r[1] && !wake_cfg_r[WAKE_MASK4_BIT] && !wake_cfg_r[WAKE_MS4_BIT])
         || (ext_irq_pin_five && !pin_prev_r[2] && !wake_cfg_r[WAKE_MASK5_BIT] && !wake_cfg_r[WAKE_MS5_BIT]);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_prev_r <= 3'h0;
      end else begin
         pin_prev_r <= {ext_irq_pin_five, ext_irq_pin_four, nmi_pin};
      end
   end

   // STOP state and stabilization timer.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stop_r <= 1'b0;
         stab_busy_r <= 1'b0;
         stab_cnt_r <= 32'h0;
      end else if (stop_r) begin
         if (wake) begin
            stop_r <= 1'b0;
            stab_busy_r <= 1'b1;
            stab_cnt_r <= 32'(STAB_SCALE) << stabilization_time_select_r;
         end
      end else if (stab_busy_r) begin
         if (stab_cnt_r <= 32'h1) begin
            stab_busy_r <= 1'b0;
         end
         stab_cnt_r <= stab_cnt_r - 32'h1;
      end else if (standby_control_reg_r[STBY_STOP_BIT] && !standby_control_reg_r[STBY_HALT_BIT]) begin
         stop_r <= 1'b1;
      end
   end

   // Pin-level outputs.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_enable <= 1'b1;
         ext_clock_fwd <= 1'b0;
         cpu_clock_gate <= 1'b0;
         regulator_on <= 1'b0;
      end else begin
         osc_enable <= !ext_clock_mode && !stop_r;
         ext_clock_fwd <= ext_clock_mode && osc_input_pin;
         cpu_clock_gate <= !stop_r && !stab_busy_r;
         regulator_on <= !regulator_disable_pin;
      end
   end

   // AXI4-Lite write: address and data taken in either order.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         aw_addr_r <= 8'h0;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_hold_r && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
         s_axi_wready <= !w_hold_r && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (aw_hold_r && w_hold_r && !s_axi_bvalid) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_r[7:4] == 4'h0 && aw_addr_r[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register writes; only byte lane 0 carries data.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         standby_control_reg_r <= STANDBY_RESET;
         stabilization_time_select_r <= STAB_SEL_RESET;
         wake_cfg_r <= WAKE_CFG_RESET;
      end else begin
         if (aw_hold_r && w_hold_r && !s_axi_bvalid && w_strb_r[0]) begin
            unique case (aw_addr_r)
               ADDR_STANDBY: standby_control_reg_r <= w_data_r[7:0] & STANDBY_MASK;
               ADDR_STAB_SEL: stabilization_time_select_r <= w_data_r[2:0];
               ADDR_WAKE_CFG: wake_cfg_r <= w_data_r[3:0];
               default: ;
            endcase
         end
         // The STOP request is consumed on wake so the device does not re-enter it.
         if (stop_r && wake) begin
            standby_control_reg_r[STBY_STOP_BIT] <= 1'b0;
         end
      end
   end

   assign div_req_r = {standby_control_reg_r[STBY_DIV_HI_BIT], standby_control_reg_r[STBY_DIV_LO_BIT]};

   // AXI4-Lite read.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
               ADDR_STANDBY: s_axi_rdata <= {24'h0, standby_control_reg_r};
               ADDR_STAB_SEL: s_axi_rdata <= {29'h0, stabilization_time_select_r};
               ADDR_WAKE_CFG: s_axi_rdata <= {28'h0, wake_cfg_r};
               ADDR_STATUS: s_axi_rdata <= {25'h0, regulator_on, stab_busy_r, stop_r, change_pend_r,
                                            osc_enable, div_cur_r};
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

/* File: clkgen_ctrl_properties.sv */
/*
  Port checker for the clock divider control block.
  Assumes it is bound into clkgen_ctrl, with aclk as the only clock.
*/
`timescale 1ns/1ps
module clkgen_ctrl_properties (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes.
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Pins and clock outputs.
   input wire logic ext_clock_mode,
   input wire logic osc_input_pin,
   input wire logic regulator_disable_pin,
   input wire logic osc_enable,
   input wire logic ext_clock_fwd,
   input wire logic sys_clk_en,
   input wire logic cpu_clock_gate,
   input wire logic regulator_on
);
   logic [3:0] gap_r;
   logic seen_r;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // The gap is only judged after a pulse seen while the clock may run, so STOP never looks like a stall.
   always_ff @(posedge aclk) begin
      if (!aresetn || !cpu_clock_gate || !osc_enable) seen_r <= 1'b0;
      else if (sys_clk_en) seen_r <= 1'b1;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) gap_r <= 4'h0;
      else if (sys_clk_en) gap_r <= 4'h1;
      else if (gap_r != 4'hf) gap_r <= gap_r + 4'h1;
   end
   a_regulator_follows_pin:
      assert property ($past(aresetn) |-> regulator_on == !$past(regulator_disable_pin)) else $error("regulator state wrong");
   a_ext_clock_forward:
      assert property ($past(aresetn) && $past(ext_clock_mode) |-> ext_clock_fwd == $past(osc_input_pin))
      else $error("external clock not forwarded");
   a_ext_clock_quiet:
      assert property ($past(aresetn) && !$past(ext_clock_mode) |-> !ext_clock_fwd) else $error("forward active in resonator mode");
   a_reset_osc_on:
      assert property ($rose(aresetn) && !ext_clock_mode |-> osc_enable) else $error("oscillator off after reset");
   a_period_legal:
      assert property (sys_clk_en && seen_r |-> gap_r inside {4'h1, 4'h2, 4'h4, 4'h8}) else $error("illegal clock period");
   a_no_stall:
      assert property (seen_r && cpu_clock_gate && osc_enable |-> gap_r <= 4'h8) else $error("system clock stalled");
   a_bvalid_holds:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write response dropped");
   a_rdata_holds:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
   a_read_answer:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
endmodule

/* File: tb_system_clock_divider_control.sv */
/*
  Self-checking bench for the clock divider control block.
  Assumes clkgen_pkg and the checker are compiled first; the bench drives every pin.
*/
`timescale 1ns/1ps
module tb_system_clock_divider_control;
   import clkgen_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ext_clock_mode = 1'b0, osc_input_pin = 1'b0;
   logic regulator_disable_pin = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic osc_enable, ext_clock_fwd, sys_clk_en, sys_clk_level, cpu_clock_gate, regulator_on;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [2:0] wk = 3'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int compares = 0, miscompares = 0, cycles = 0;
   clkgen_ctrl #(.STAB_SCALE(4)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_clock_mode,
      .osc_input_pin, .nmi_pin(wk[0]), .ext_irq_pin_four(wk[1]), .ext_irq_pin_five(wk[2]), .regulator_disable_pin,
      .osc_enable, .ext_clock_fwd, .sys_clk_level, .sys_clk_en, .cpu_clock_gate, .regulator_on);
   always #20 aclk = ~aclk;
   task automatic close_out();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(RESP_OKAY));
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Counts edges between two system clock pulses.
   task automatic per(output logic [31:0] p);
      int n;
      n = 0;
      while (sys_clk_en !== 1'b1 && n < 100) begin
         @(posedge aclk);
         n++;
      end
      @(posedge aclk);
      p = 32'h1;
      while (sys_clk_en !== 1'b1 && p < 100) begin
         @(posedge aclk);
         p++;
      end
   endtask
   task automatic pulse(input int i);
      @(posedge aclk);
      wk[i] <= 1'b1;
      repeat (2) @(posedge aclk);
      wk[i] <= 1'b0;
   endtask
   function automatic logic [31:0] ratio(input logic [1:0] s);
      return 32'h1 << s;
   endfunction
   function automatic int bound(input logic [1:0] s);
      return s == 2'h0 ? CHG_MAX_DIV1 : s == 2'h1 ? CHG_MAX_DIV2 : CHG_MAX_DIV48;
   endfunction
   initial begin
      logic [31:0] v;
      logic [1:0] r, sel, old, st;
      int n;
      v = $urandom(26788);
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ADDR_STANDBY, v, r);
      chk(v, 32'(STANDBY_RESET));
      per(v);
      chk(v, ratio(2'h3));
      $display("test reset done");
      old = 2'h3;
      for (int i = 0; i < 8; i++) begin
         sel = i < 4 ? 2'(i) : 2'($urandom);
         // Bit 6 is reserved and must read back as zero.
         wr(ADDR_STANDBY, (32'(sel) << 4) | ($urandom & 32'h40));
         repeat (bound(old) + 2) @(posedge aclk);
         per(v);
         chk(v, ratio(sel));
         // The pulse marks the end of the low half; only the undivided clock stays high.
         chk(32'(sys_clk_level), 32'(sel == 2'h0));
         rd(ADDR_STANDBY, v, r);
         chk(v, 32'(sel) << 4);
         old = sel;
      end
      rd(8'h10, v, r);
      chk(32'(r), 32'(RESP_SLVERR));
      chk(v, 32'h0);
      // A write without byte lane 0 must leave the divide select untouched.
      s_axi_wstrb <= 4'he;
      wr(ADDR_STANDBY, 32'(~old) << 4);
      s_axi_wstrb <= 4'hf;
      rd(ADDR_STANDBY, v, r);
      chk(v, 32'(old) << 4);
      $display("test ratio done");
      ext_clock_mode <= 1'b1;
      repeat (8) begin
         @(posedge aclk);
         osc_input_pin <= 1'($urandom);
         regulator_disable_pin <= 1'($urandom);
         repeat (2) @(posedge aclk);
         #1;
         chk(32'(ext_clock_fwd), 32'(osc_input_pin));
         chk(32'(regulator_on), 32'(!regulator_disable_pin));
      end
      @(posedge aclk);
      ext_clock_mode <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(32'(ext_clock_fwd), 32'h0);
      $display("test pins done");
      for (int w = 0; w < 2; w++) begin
         st = 2'($urandom);
         wr(ADDR_STAB_SEL, 32'(st));
         wr(ADDR_WAKE_CFG, w == 0 ? 32'h1 : 32'h4);
         wr(ADDR_STANDBY, 32'h2);
         repeat (4) @(posedge aclk);
         chk(32'(osc_enable), 32'h0);
         pulse(1);
         repeat (10) @(posedge aclk);
         chk(32'(osc_enable), 32'h0);
         pulse(w == 0 ? 0 : 2);
         n = 0;
         while (sys_clk_en !== 1'b1 && n < 200) begin
            @(posedge aclk);
            n++;
         end
         chk(32'(n >= (4 << st) - 1 && n < 200), 32'h1);
         chk(32'(osc_enable), 32'h1);
         rd(ADDR_STANDBY, v, r);
         chk(v, 32'h0);
      end
      $display("test stop done");
      close_out();
   end
endmodule
bind clkgen_ctrl clkgen_ctrl_properties props (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .ext_clock_mode, .osc_input_pin,
   .regulator_disable_pin, .osc_enable, .ext_clock_fwd, .sys_clk_en, .cpu_clock_gate, .regulator_on);
